// ===== core/pwr_mode_pkg.sv
// Package for the bridge power-mode sequencer: register map, field positions,
// reset values and the enumerations shared by design and bench.
// Assumes a 32-bit AXI4-Lite register bus on a single 250 MHz clock.
package pwr_mode_pkg;

   // Register byte offsets
   localparam logic [7:0] power_mgmt_config_reg_off = 8'h00;
   localparam logic [7:0] processor_iface_config1_off = 8'h04;
   localparam logic [7:0] mem_ctrl_config8_off = 8'h08;
   localparam logic [7:0] status_off = 8'h0c;

   // Power management config fields
   localparam int doze_sel_bit = 0;
   localparam int nap_sel_bit = 1;
   localparam int sleep_sel_bit = 2;
   localparam int legacy_handshake_required_bit = 3;
   localparam int second_cpu_wake_enable_bit = 4;
   localparam int lowpower_refresh_enable_bit = 5;
   localparam int snoop_run_disable_bit = 6;
   localparam int global_lowpower_enable_bit = 7;

   // Processor interface config fields
   localparam int machine_check_report_enable_bit = 0;
   localparam int cpu_kind_lsb = 1;

   // Memory controller config field
   localparam int self_refresh_select_bit = 0;

   // Reset values
   localparam logic [7:0] pmcfg_reset = 8'h00;
   localparam logic [2:0] picfg_reset = 3'h0;
   localparam logic self_refresh_reset = 1'b0;

   // Bus responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // Processor kinds: legacy (optional handshake), quiesce pins, stop/go pins
   typedef enum logic [1:0] {
      cpu_legacy,
      cpu_quiesce,
      cpu_stopgo,
      cpu_spare
   } cpu_kind_e;

   // Power states
   typedef enum logic [2:0] {
      st_full_on,
      st_doze,
      st_nap,
      st_sleep,
      st_suspend
   } pwr_state_e;

   // Wake event inputs from the rest of the bridge and pins
   typedef struct packed {
      logic pci_mem_hit;
      logic cpu0_bus_request;
      logic cpu1_bus_request;
      logic nmi;
   } wake_s;

   // Refresh selection toward the memory controller
   typedef struct packed {
      logic refresh_run;
      logic self_refresh;
      logic cas_before_ras;
   } refresh_s;

endpackage : pwr_mode_pkg

// ===== core/bridge_power_mode_controller.sv
// Power-mode sequencer of the host bridge: full-on, doze, nap, sleep, suspend.
// Assumes pins (quiesce request, suspend, bus requests, nmi) are asynchronous
// and PCI hit / service-busy come from logic on clk_sys.
//
// Behaviour
// - Doze, nap, sleep by bits; suspend by pin
// - No low-power state without global enable
// - Quiesce request enters nap/sleep, acknowledge answers
// - Doze enters on select and enable with no wake pending
// - Nap/sleep need select, enable, active request
// - Processor kind flips request/acknowledge polarity
// - Legacy kind: handshake bit gates request wait
// - Suspend entered on pin low, left high
// - Full-on after reset
// - Doze/nap keep decode, refresh, request, nmi monitors
// - Doze wakes on hit, bus request, enabled nmi
// - Return to doze when idle and enabled
// - Nap serves hits in place; wakes on requests (second if enabled), enabled nmi
// - Non-PCI nap wake clears global enable
// - Go held through all of nap; snoop run disable does not drop it
// - Sleep ignores PCI hits, wakes on others
// - Every sleep wake clears global enable
// - Low-power refresh: off, self or CBR
// - Suspend ignores everything but the pin
`timescale 1ns/1ps
module bridge_power_mode_controller
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Processor handshake pins (pin levels, active low for quiesce kind)
   input wire logic quiesce_request_pin,
   output logic quiesce_acknowledge_pin,
   // Suspend pin, low requests suspend
   input wire logic suspend_n,
   // Wake sources: pins are asynchronous, pci_mem_hit is on clk_sys
   input wire pwr_mode_pkg::wake_s wake_in,
   // PCI service still in progress, on clk_sys
   input wire logic pci_service_busy,
   // State and unit controls
   output pwr_mode_pkg::pwr_state_e power_state,
   output logic units_full_clock,
   output logic pci_decode_enable,
   output pwr_mode_pkg::refresh_s refresh_ctrl
);

   // Registers
   logic [7:0] pmcfg_q;
   logic [2:0] picfg_q;
   logic self_refresh_q;
   pwr_state_e state_q;
   pwr_state_e state_d;
   logic ack_q;
   logic pci_wake_q;
   logic clear_enable;

   // Two-flop synchronisers for pins; only stage two is read
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic [4:0] pins_raw;
   assign pins_raw = {quiesce_request_pin, suspend_n, wake_in.cpu0_bus_request,
                      wake_in.cpu1_bus_request, wake_in.nmi};

   // Pins cross from outside the clock domain
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         // Idle levels: request and suspend high, bus requests high, nmi low;
         // any other value would look like a wake right after reset
         sync1_q <= 5'h1e;
         sync2_q <= 5'h1e;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   logic quiesce_request_pin_s;
   logic suspend_n_s;
   logic br0_s;
   logic br1_s;
   logic nmi_s;
   assign quiesce_request_pin_s = sync2_q[4];
   assign suspend_n_s = sync2_q[3];
   assign br0_s = sync2_q[2];
   assign br1_s = sync2_q[1];
   assign nmi_s = sync2_q[0];

   // Config field views
   logic pm_en;
   logic machine_check_report_enable;
   cpu_kind_e kind;
   assign pm_en = pmcfg_q[global_lowpower_enable_bit];
   assign machine_check_report_enable = picfg_q[machine_check_report_enable_bit];
   assign kind = cpu_kind_e'(picfg_q[cpu_kind_lsb +: 2]);

   // Request seen active: stop/go kind uses a high stop level
   logic quiesce_request_active;
   // Spare kind behaves like the quiesce kind
   assign quiesce_request_active = (kind == cpu_stopgo) ? quiesce_request_pin_s : !quiesce_request_pin_s;

   // Legacy kind may skip the handshake when not required
   logic quiesce_request_ok;
   always_comb begin
      if (kind == cpu_legacy && !pmcfg_q[legacy_handshake_required_bit]) begin
         quiesce_request_ok = 1'b1;
      end else begin
         quiesce_request_ok = quiesce_request_active;
      end
   end

   // Wake sources per state; bus requests are active low pins
   logic br0_req;
   logic br1_req;
   logic nmi_wake;
   logic wake_common;
   // Pin wakes arrive two to three cycles late through the synchronisers
   assign br0_req = !br0_s;
   assign br1_req = !br1_s;
   assign nmi_wake = nmi_s && machine_check_report_enable;
   // Doze wakes on either request unconditionally
   logic doze_wake;
   assign doze_wake = wake_in.pci_mem_hit || br0_req || br1_req || nmi_wake;
   assign wake_common = br0_req || (br1_req && pmcfg_q[second_cpu_wake_enable_bit])
                        || nmi_wake;

   // State decision; suspend wins in full-on, yields to wakes in doze, and ignores all else
   always_comb begin
      state_d = state_q;
      clear_enable = 1'b0;
      case (state_q)
         st_full_on: begin
            if (pm_en && !suspend_n_s) begin
               state_d = st_suspend;
            end else if (pci_service_busy) begin
               state_d = st_full_on; // Finish pending service first
            end else if (pm_en && pmcfg_q[sleep_sel_bit] && quiesce_request_ok) begin
               state_d = st_sleep;
            end else if (pm_en && pmcfg_q[nap_sel_bit] && quiesce_request_ok) begin
               state_d = st_nap;
            end else if (pm_en && pmcfg_q[doze_sel_bit] && !doze_wake) begin
               // A wake source still pending keeps full-on; going back at once
               // would bounce between doze and full-on every cycle
               state_d = st_doze;
            end
         end
         st_doze: begin
            if (!pm_en || !pmcfg_q[doze_sel_bit] || doze_wake) begin
               state_d = st_full_on;
            end else if (!suspend_n_s) begin
               state_d = st_suspend;
            end
         end
         st_nap: begin
            if (wake_common) begin
               state_d = st_full_on;
               clear_enable = 1'b1;
            end else if (wake_in.pci_mem_hit || pci_service_busy) begin
               state_d = st_nap; // PCI served in place, enable kept
            end else if (!pm_en || !pmcfg_q[nap_sel_bit]) begin
               state_d = st_full_on;
            end
         end
         st_sleep: begin
            // PCI hits are not looked at: decode is off in sleep
            if (wake_common) begin
               state_d = st_full_on;
               clear_enable = 1'b1;
            end
         end
         st_suspend: begin
            // Nothing but the synchronised pin is looked at here
            if (suspend_n_s) begin
               state_d = st_full_on;
            end
         end
         default: state_d = st_full_on;
      endcase
   end

   // State register; reset lands in full-on
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= st_full_on;
      end else begin
         state_q <= state_d;
      end
   end

   // PCI service during nap tracked for the go output
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pci_wake_q <= 1'b0;
      end else begin
         // Only while nap is kept; a wake that leaves nap must not stretch go
         // into full-on for a cycle
         pci_wake_q <= (state_d == st_nap) && (wake_in.pci_mem_hit || pci_service_busy);
      end
   end

   // Acknowledge raised once the state is reached, dropped on full-on
   // Registered so the pin never glitches while the state decision settles
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else if (state_d == st_nap || state_d == st_sleep) begin
         ack_q <= 1'b1;
      end else begin
         ack_q <= 1'b0;
      end
   end

   // Go asserted during nap PCI service even with snoop run disabled, as ack_q already covers all of nap
   logic ack_active;
   assign ack_active = ack_q || (pci_wake_q && kind == cpu_stopgo
                                 && !pmcfg_q[snoop_run_disable_bit]);
   // Stop/go kind drives go high as active; others drive active low
   always_comb begin
      if (kind == cpu_stopgo) begin
         quiesce_acknowledge_pin = ack_active;
      end else begin
         quiesce_acknowledge_pin = !ack_active;
      end
   end

   // Unit controls per state
   assign power_state = state_q;
   // Doze and nap keep decoding so a PCI hit can wake or be served
   assign units_full_clock = (state_q == st_full_on);
   assign pci_decode_enable = (state_q == st_full_on) || (state_q == st_doze)
                              || (state_q == st_nap);

   // Refresh: normal in full-on/doze/nap, chosen by bits in sleep/suspend
   // Limitation: no rate control here, the memory side times the refresh
   always_comb begin
      refresh_ctrl = '0;
      if (state_q == st_sleep || state_q == st_suspend) begin
         if (pmcfg_q[lowpower_refresh_enable_bit]) begin
            refresh_ctrl.refresh_run = 1'b1;
            refresh_ctrl.self_refresh = self_refresh_q;
            refresh_ctrl.cas_before_ras = !self_refresh_q;
         end
      end else begin
         refresh_ctrl.refresh_run = 1'b1;
         refresh_ctrl.cas_before_ras = 1'b1;
      end
   end

   // AXI4-Lite write: take address and data in either order, answer after both
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_fire = aw_held_q && w_held_q;

   // Write channel capture and response
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= resp_okay;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
               power_mgmt_config_reg_off, processor_iface_config1_off,
               mem_ctrl_config8_off, status_off: s_axi_bresp <= resp_okay;
               // Unmapped offsets still complete, with an error response
               default: s_axi_bresp <= resp_slverr;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Config registers; hardware clear of enable beats a software write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pmcfg_q <= pmcfg_reset;
         picfg_q <= picfg_reset;
         self_refresh_q <= self_refresh_reset;
      end else begin
         // Only the low byte lane carries bits; upper lanes are ignored
         if (wr_fire && wstrb_q[0]) begin
            case (awaddr_q)
               power_mgmt_config_reg_off: pmcfg_q <= wdata_q[7:0];
               processor_iface_config1_off: picfg_q <= wdata_q[2:0];
               mem_ctrl_config8_off: self_refresh_q <= wdata_q[0];
               default: ;
            endcase
         end
         if (clear_enable) begin
            pmcfg_q[global_lowpower_enable_bit] <= 1'b0;
         end
      end
   end

   // AXI4-Lite read: one cycle to data, held until taken
   // A new address waits while data is pending, so rdata stays coherent
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= resp_okay;
         case (s_axi_araddr)
            power_mgmt_config_reg_off: s_axi_rdata <= {24'h000000, pmcfg_q};
            processor_iface_config1_off: s_axi_rdata <= {29'h0, picfg_q};
            mem_ctrl_config8_off: s_axi_rdata <= {31'h0, self_refresh_q};
            status_off: s_axi_rdata <= {28'h0, ack_q, state_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= resp_slverr;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : bridge_power_mode_controller

// ===== testbench/power_mode_chk.sv
// Assertions on the ports of the power-mode sequencer.
// Assumes one clock domain and wake pins synchronised by two flops.
`timescale 1ns/1ps
module power_mode_chk
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Pins
   input wire logic suspend_n,
   input wire logic quiesce_acknowledge_pin,
   input wire pwr_mode_pkg::wake_s wake_in,
   // State
   input wire pwr_mode_pkg::pwr_state_e power_state,
   input wire logic units_full_clock
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // No pin wake for four cycles, enough to flush the sync flops
   sequence s_quiet;
      (wake_in.cpu0_bus_request && wake_in.cpu1_bus_request && !wake_in.nmi && suspend_n)[*4];
   endsequence
   // First bus request held three cycles in one state
   sequence s_req0(pwr_state_e s);
      (power_state == s && !wake_in.cpu0_bus_request)[*3];
   endsequence
   property p_full_clock;
      units_full_clock == (power_state == st_full_on);
   endproperty
   property p_susp_hold;
      (power_state == st_suspend && !suspend_n) |=> power_state == st_suspend;
   endproperty
   property p_susp_exit;
      (power_state == st_suspend && suspend_n)[*3] |-> ##[0:3] power_state != st_suspend;
   endproperty
   // A PCI hit alone never wakes sleep
   property p_sleep_pci;
      s_quiet ##0 (power_state == st_sleep && wake_in.pci_mem_hit) |=> power_state == st_sleep;
   endproperty
   property p_doze_wake;
      s_req0(st_doze) |-> ##[0:3] power_state == st_full_on;
   endproperty
   property p_nap_wake;
      s_req0(st_nap) |-> ##[0:3] power_state == st_full_on;
   endproperty
   // Acknowledge moves on entry to nap or sleep and on the way back
   property p_ack_on;
      ($changed(power_state) && power_state inside {st_nap, st_sleep})
         |-> $changed(quiesce_acknowledge_pin);
   endproperty
   property p_ack_off;
      ($past(power_state) inside {st_nap, st_sleep} && power_state == st_full_on)
         |-> $changed(quiesce_acknowledge_pin);
   endproperty
   a_full_clock: assert property (p_full_clock) else $error("unit clock wrong");
   a_susp_hold: assert property (p_susp_hold) else $error("left suspend early");
   a_susp_exit: assert property (p_susp_exit) else $error("stuck in suspend");
   a_sleep_pci: assert property (p_sleep_pci) else $error("sleep woke on hit");
   a_doze_wake: assert property (p_doze_wake) else $error("doze missed wake");
   a_nap_wake: assert property (p_nap_wake) else $error("nap missed wake");
   a_ack_on: assert property (p_ack_on) else $error("no ack on entry");
   a_ack_off: assert property (p_ack_off) else $error("ack kept on wake");
endmodule : power_mode_chk
bind bridge_power_mode_controller power_mode_chk i_chk (
   .clk_sys(clk_sys), .rstn(rstn), .suspend_n(suspend_n),
   .quiesce_acknowledge_pin(quiesce_acknowledge_pin), .wake_in(wake_in),
   .power_state(power_state), .units_full_clock(units_full_clock)
);

// ===== testbench/host_ctrl_model.sv
// Model of the host processor and the outside power controller.
// Assumes commands change just after a rising edge; pins follow one edge later.
`timescale 1ns/1ps
module host_ctrl_model
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Processor kind; wanted request, bus0, bus1, nmi, suspend
   input wire logic [1:0] kind,
   input wire logic [4:0] want,
   // Pins toward the bridge
   output logic quiesce_request_pin,
   output logic cpu0_n,
   output logic cpu1_n,
   output logic nmi,
   output logic suspend_n
);
   // Request level follows the kind: stop/go is active high
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         quiesce_request_pin <= 1'b1;
      end else begin
         quiesce_request_pin <= want[4] ^ (kind != cpu_stopgo);
      end
   end
   // Clock never stops here, so wakes pass at once; a gating
   // controller would hold them until relock had passed
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cpu0_n <= 1'b1;
         cpu1_n <= 1'b1;
         nmi <= 1'b0;
         suspend_n <= 1'b1;
      end else begin
         cpu0_n <= !want[3];
         cpu1_n <= !want[2];
         nmi <= want[1];
         suspend_n <= !want[0];
      end
   end
endmodule : host_ctrl_model

// ===== testbench/tb.sv
// Self-checking bench for the power-mode sequencer.
// Assumes the package register map and the host model beside the block.
`timescale 1ns/1ps
module tb;
   import pwr_mode_pkg::*;
   localparam logic [7:0] cfg_a = power_mgmt_config_reg_off;
   // Bus, pins and state
   logic clk_sys, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, qpin, quiesce_acknowledge, susp_n, c0n, c1n, nmi, pde;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, kind;
   logic [6:0] cmd; // Hit, busy, request, bus0, bus1, nmi, suspend
   wake_s wake;
   pwr_state_e power_state;
   refresh_s refresh_ctrl;
   int error_cnt, n_compared;
   assign wake = {cmd[6], c0n, c1n, nmi};
   bridge_power_mode_controller i_dut (
      .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .quiesce_request_pin(qpin), .quiesce_acknowledge_pin(quiesce_acknowledge), .suspend_n(susp_n),
      .wake_in(wake), .pci_service_busy(cmd[5]), .power_state(power_state),
      .units_full_clock(), .pci_decode_enable(pde), .refresh_ctrl(refresh_ctrl));
   host_ctrl_model i_host (.clk_sys(clk_sys), .rstn(rstn), .kind(kind), .want(cmd[4:0]),
      .quiesce_request_pin(qpin), .cpu0_n(c0n), .cpu1_n(c1n), .nmi(nmi), .suspend_n(susp_n));
   task automatic stop_test();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo();
      error_cnt++;
      $display("ERROR %0t: wait timed out", $time);
      stop_test();
   endtask : tmo
   // Readies are sampled mid-cycle so the edge decision never races the design
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic [2:0] h;
      n = 0;
      @(posedge clk_sys);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do begin
         @(negedge clk_sys);
         n++;
         h = {awready, wready, bvalid};
         if (h[0]) chk(32'(bresp), 32'(er));
         @(posedge clk_sys);
         if (h[2]) awvalid <= 1'b0;
         if (h[1]) wvalid <= 1'b0;
         if (h[0]) bready <= 1'b0;
      end while (!h[0] && n < 50);
      if (!h[0]) tmo();
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic [1:0] h;
      n = 0;
      @(posedge clk_sys);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(negedge clk_sys);
         n++;
         h = {arready, rvalid};
         if (h[0]) chk(rdata, e);
         if (h[0]) chk(32'(rresp), 32'(er));
         @(posedge clk_sys);
         if (h[1]) arvalid <= 1'b0;
         if (h[0]) rready <= 1'b0;
      end while (!h[0] && n < 50);
      if (!h[0]) tmo();
   endtask : rc
   task automatic wc(input logic [31:0] d);
      wr(cfg_a, d, resp_okay);
   endtask : wc
   task automatic drv(input logic [6:0] v);
      @(posedge clk_sys);
      cmd <= v;
   endtask : drv
   task automatic set_kind(input cpu_kind_e k);
      @(posedge clk_sys);
      kind <= k;
      wr(processor_iface_config1_off, 32'({k, 1'b0}), resp_okay);
   endtask : set_kind
   task automatic wst(input pwr_state_e s);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (power_state !== s && n < 40);
      if (power_state !== s) tmo();
      chk(32'(power_state), 32'(s));
   endtask : wst
   task automatic hold(input pwr_state_e s);
      repeat (8) @(negedge clk_sys);
      chk(32'(power_state), 32'(s));
   endtask : hold
   task automatic t_reset();
      rc(cfg_a, 32'(pmcfg_reset), resp_okay);
      rc(processor_iface_config1_off, 32'(picfg_reset), resp_okay);
      rc(mem_ctrl_config8_off, 32'(self_refresh_reset), resp_okay);
      rc(status_off, 32'h0, resp_okay);
      wr(8'h10, 32'hff, resp_slverr);
      rc(8'h10, 32'h0, resp_slverr);
   endtask : t_reset
   task automatic t_doze();
      wc(32'h01);
      hold(st_full_on);
      wc(32'h81);
      wst(st_doze);
      chk(32'(pde), 32'h1);
      drv(7'h08);
      wst(st_full_on);
      drv(7'h00);
      wst(st_doze);
      drv(7'h08);
      wst(st_full_on);
      wc(32'h00);
      drv(7'h00);
      hold(st_full_on);
      wr(processor_iface_config1_off, 32'h1, resp_okay);
      wc(32'h81);
      wst(st_doze);
      drv(7'h02);
      wst(st_full_on);
      drv(7'h00);
      wst(st_doze);
      drv(7'h40);
      wst(st_full_on);
      drv(7'h00);
      wst(st_doze);
      wc(32'h00);
      wst(st_full_on);
   endtask : t_doze
   task automatic t_nap();
      set_kind(cpu_quiesce);
      wc(32'h82);
      hold(st_full_on);
      drv(7'h10);
      wst(st_nap);
      chk(32'(quiesce_acknowledge), 32'h0);
      rc(status_off, 32'h0a, resp_okay);
      drv(7'h70);
      drv(7'h30);
      hold(st_nap);
      drv(7'h10);
      rc(cfg_a, 32'h82, resp_okay);
      drv(7'h18);
      wst(st_full_on);
      chk(32'(quiesce_acknowledge), 32'h1);
      rc(cfg_a, 32'h02, resp_okay);
   endtask : t_nap
   task automatic t_sleep();
      wr(mem_ctrl_config8_off, 32'h1, resp_okay);
      drv(7'h10);
      wc(32'ha4);
      wst(st_sleep);
      chk(32'(refresh_ctrl), 32'h6);
      chk(32'(pde), 32'h0);
      drv(7'h50);
      drv(7'h16);
      hold(st_sleep);
      drv(7'h18);
      wst(st_full_on);
      rc(cfg_a, 32'h24, resp_okay);
      wr(mem_ctrl_config8_off, 32'h0, resp_okay);
      drv(7'h10);
      wc(32'hb4);
      wst(st_sleep);
      chk(32'(refresh_ctrl), 32'h5);
      drv(7'h14);
      wst(st_full_on);
      rc(cfg_a, 32'h34, resp_okay);
      drv(7'h00);
   endtask : t_sleep
   task automatic t_kinds();
      set_kind(cpu_stopgo);
      wc(32'h82);
      drv(7'h10);
      wst(st_nap);
      chk(32'(quiesce_acknowledge), 32'h1);
      drv(7'h18);
      wst(st_full_on);
      chk(32'(quiesce_acknowledge), 32'h0);
      drv(7'h00);
      set_kind(cpu_legacy);
      wc(32'h82);
      wst(st_nap);
      drv(7'h08);
      wst(st_full_on);
      drv(7'h00);
      wc(32'h8a);
      hold(st_full_on);
   endtask : t_kinds
   task automatic t_susp();
      wc(32'h00);
      drv(7'h01);
      hold(st_full_on);
      wc(32'h80);
      wst(st_suspend);
      chk(32'(refresh_ctrl.refresh_run), 32'h0);
      drv(7'h09);
      hold(st_suspend);
      drv(7'h00);
      wst(st_full_on);
   endtask : t_susp
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, cmd, kind} = '0;
      error_cnt = 0;
      n_compared = 0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_doze();
      t_nap();
      t_sleep();
      t_kinds();
      t_susp();
      stop_test();
   end
endmodule : tb
